// File: usb_uart_dma_channels.v
`include "usb_uart_dma_map.vh"
`default_nettype none

// ****************************************
// Byte FIFO
// ****************************************
module usb_uart_dma_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset
	input wire clk_sys,
	input wire resetn,
	// Fill side
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	// Drain side
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	localparam [31:0] DEPTH_W = DEPTH;
	localparam [AW:0] FULL = DEPTH_W[AW:0]; // Cut to occupancy width
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;

	// Handshake terms
	assign in_ready = (count != FULL);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Pointers and occupancy
	always @(posedge clk_sys) begin
		if (!resetn) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				mem[wr_ptr] <= in_data;
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule // usb_uart_dma_fifo

// ****************************************
// Two-channel UART DMA controller
// ****************************************
module usb_uart_dma_channels (
	// Clock and reset
	input wire clk_sys,
	input wire resetn,
	// Register port
	input wire [15:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// Shared SRAM port
	output reg mem_rd,
	output reg mem_wr,
	output reg [15:0] mem_addr,
	output reg [7:0] mem_wdata,
	input wire [7:0] mem_rdata,
	input wire mem_ack,
	// Buffer manager, transmit side
	output reg [2:0] ubm_tx_edb,
	output reg ubm_tx_select,
	input wire ubm_tx_loaded,
	input wire [15:0] ubm_tx_base,
	input wire [6:0] ubm_tx_count,
	output reg ubm_tx_done,
	// Buffer manager, receive side
	output reg [2:0] ubm_rx_edb,
	output reg ubm_rx_select,
	input wire ubm_rx_free,
	input wire [15:0] ubm_rx_base,
	output reg ubm_rx_done,
	output reg [6:0] ubm_rx_count,
	output reg ubm_rx_nak,
	input wire ubm_error,
	// UART transmit holding register
	output reg [7:0] uart_tx_data,
	output reg uart_tx_valid,
	input wire uart_tx_ready,
	// UART receive holding register
	input wire [7:0] uart_rx_data,
	input wire uart_rx_valid,
	output reg uart_rx_ready,
	// Completion interrupts
	output reg tx_irq,
	output reg rx_irq
);
	localparam [3:0] T_IDLE = 4'b0001;
	localparam [3:0] T_WAIT = 4'b0010;
	localparam [3:0] T_READ = 4'b0100;
	localparam [3:0] T_DATA = 4'b1000;
	localparam [4:0] R_IDLE = 5'b00001;
	localparam [4:0] R_WAIT = 5'b00010;
	localparam [4:0] R_GET = 5'b00100;
	localparam [4:0] R_PUT = 5'b01000;
	localparam [4:0] R_ACK = 5'b10000;
	localparam [31:0] TMO_W = `TIMEOUT_CYC;
	localparam [11:0] TMO = TMO_W[11:0]; // Cut to timer width

	// Channel control state
	reg tx_en, tx_ine, tx_cnt_mode, tx_partial_packet_flag;
	reg rx_en, rx_ine, rx_cnt_mode, rx_tmo;
	reg [3:0] tx_state;
	reg [4:0] rx_state;
	reg [6:0] tx_len, tx_idx, rx_idx;
	reg [11:0] tx_timer, rx_timer;
	reg [7:0] rx_byte;
	reg mem_busy, mem_owner_rx;
	wire tx_want, rx_want, tx_ack, rx_ack;
	wire tx_wsel, rx_wsel, tx_ssel, rx_ssel;
	wire fifo_in_ready, fifo_out_valid, fifo_pull;
	wire [7:0] fifo_out_data;

	// Address within an endpoint buffer
	function [15:0] buf_addr;
		input [15:0] base;
		input [6:0] idx;
		begin
			buf_addr = base + {9'h000, idx};
		end
	endfunction

	// Channel definition byte, direction bit fixed per channel
	function [7:0] def_byte;
		input en, completion_interrupt_enable, cnt, xy, dir;
		input [2:0] edb;
		begin
			def_byte = {en, completion_interrupt_enable, cnt, xy, dir, edb};
		end
	endfunction

	// Register decode
	assign tx_wsel = reg_wr && (reg_addr == `TX_DEF_ADDR);
	assign rx_wsel = reg_wr && (reg_addr == `RX_DEF_ADDR);
	assign tx_ssel = reg_wr && (reg_addr == `TX_STAT_ADDR);
	assign rx_ssel = reg_wr && (reg_addr == `RX_STAT_ADDR);

	// SRAM arbitration, transmit first
	assign tx_want = (tx_state == T_READ) && (tx_idx != tx_len) &&
		fifo_in_ready && !mem_busy;
	assign rx_want = (rx_state == R_PUT) && !mem_busy && !tx_want;
	assign tx_ack = mem_ack && mem_busy && !mem_owner_rx;
	assign rx_ack = mem_ack && mem_busy && mem_owner_rx;
	assign fifo_pull = !uart_tx_valid || uart_tx_ready;

	// Byte path from SRAM toward the UART
	usb_uart_dma_fifo #(
		.WIDTH(8),
		.DEPTH(`FIFO_DEPTH),
		.AW(4)
	) tx_fifo (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.in_data(mem_rdata),
		.in_valid(tx_ack && (tx_state == T_DATA)),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pull)
	);

	// Output stage into the transmit holding register
	always @(posedge clk_sys) begin
		if (!resetn) begin
			uart_tx_valid <= 1'b0;
			uart_tx_data <= `RDATA_RST;
		end else if (fifo_pull) begin
			uart_tx_valid <= fifo_out_valid;
			uart_tx_data <= fifo_out_data;
		end
	end

	// SRAM request generation
	always @(posedge clk_sys) begin
		if (!resetn) begin
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			mem_addr <= 16'h0000;
			mem_wdata <= `RDATA_RST;
			mem_busy <= 1'b0;
			mem_owner_rx <= 1'b0;
		end else begin
			mem_rd <= tx_want;
			mem_wr <= rx_want;
			if (tx_want) begin
				mem_addr <= buf_addr(ubm_tx_base, tx_idx);
				mem_busy <= 1'b1;
				mem_owner_rx <= 1'b0;
			end else if (rx_want) begin
				mem_addr <= buf_addr(ubm_rx_base, rx_idx);
				mem_wdata <= rx_byte;
				mem_busy <= 1'b1;
				mem_owner_rx <= 1'b1;
			end else if (mem_ack) begin
				mem_busy <= 1'b0;
			end
		end
	end

	// ****************************************
	// Transmit channel
	// ****************************************
	always @(posedge clk_sys) begin
		if (!resetn) begin
			tx_en <= `BIT_RST;
			tx_ine <= `BIT_RST;
			tx_cnt_mode <= `BIT_RST;
			ubm_tx_select <= `BIT_RST;
			ubm_tx_edb <= `EDB_RST;
			tx_partial_packet_flag <= `BIT_RST;
			tx_state <= T_IDLE;
			tx_len <= 7'h00;
			tx_idx <= 7'h00;
			tx_timer <= 12'h000;
			ubm_tx_done <= 1'b0;
			tx_irq <= 1'b0;
		end else begin
			ubm_tx_done <= 1'b0;
			tx_irq <= 1'b0;
			if (tx_wsel) begin
				ubm_tx_edb <= reg_wdata[`DEF_EDB_HI:`DEF_EDB_LO];
				ubm_tx_select <= reg_wdata[`DEF_XY];
				tx_cnt_mode <= reg_wdata[`DEF_CNT];
				tx_ine <= reg_wdata[`DEF_INE];
				tx_en <= reg_wdata[`DEF_EN];
				tx_irq <= tx_en && !reg_wdata[`DEF_EN] &&
					reg_wdata[`DEF_INE];
			end
			if (tx_ssel && reg_wdata[`STAT_FLAG])
				tx_partial_packet_flag <= 1'b0;
			case (tx_state)
			T_IDLE: begin
				if (tx_en) begin
					tx_timer <= 12'h000;
					tx_state <= T_WAIT;
				end
			end
			T_WAIT: begin
				tx_timer <= tx_timer + 1'b1;
				if (ubm_tx_loaded) begin
					tx_len <= ubm_tx_count;
					tx_idx <= 7'h00;
					tx_state <= T_READ;
				end else if (tx_timer == TMO - 1'b1) begin
					tx_en <= 1'b0;
					tx_irq <= tx_ine;
					tx_state <= T_IDLE;
				end
			end
			T_READ: begin
				if (tx_want) begin
					tx_state <= T_DATA;
				end else if (tx_idx == tx_len) begin
					ubm_tx_done <= 1'b1;
					ubm_tx_select <= ~ubm_tx_select;
					tx_timer <= 12'h000;
					tx_state <= T_WAIT;
					if (tx_len < `BUF_SIZE) begin
						tx_partial_packet_flag <= 1'b1;
						if (tx_ine) begin
							tx_en <= 1'b0;
							tx_irq <= 1'b1;
							tx_state <= T_IDLE;
						end
					end
				end
			end
			T_DATA: begin
				if (tx_ack) begin
					tx_idx <= tx_idx + 1'b1;
					tx_state <= T_READ;
				end
			end
			default: tx_state <= T_IDLE;
			endcase
			if (tx_en && ubm_error) begin
				tx_en <= 1'b0;
				tx_irq <= tx_ine;
				tx_state <= T_IDLE;
			end else if (!tx_en && !tx_wsel) begin
				tx_state <= T_IDLE;
			end
		end
	end

	// ****************************************
	// Receive channel
	// ****************************************
	always @(posedge clk_sys) begin
		if (!resetn) begin
			rx_en <= `BIT_RST;
			rx_ine <= `BIT_RST;
			rx_cnt_mode <= `BIT_RST;
			ubm_rx_select <= `BIT_RST;
			ubm_rx_edb <= `EDB_RST;
			rx_tmo <= `BIT_RST;
			rx_state <= R_IDLE;
			rx_idx <= 7'h00;
			rx_timer <= 12'h000;
			rx_byte <= `RDATA_RST;
			uart_rx_ready <= 1'b0;
			ubm_rx_done <= 1'b0;
			ubm_rx_count <= 7'h00;
			ubm_rx_nak <= 1'b1;
			rx_irq <= 1'b0;
		end else begin
			ubm_rx_done <= 1'b0;
			rx_irq <= 1'b0;
			if (rx_wsel) begin
				ubm_rx_edb <= reg_wdata[`DEF_EDB_HI:`DEF_EDB_LO];
				ubm_rx_select <= reg_wdata[`DEF_XY];
				rx_cnt_mode <= reg_wdata[`DEF_CNT];
				rx_ine <= reg_wdata[`DEF_INE];
				rx_en <= reg_wdata[`DEF_EN];
				rx_irq <= rx_en && !reg_wdata[`DEF_EN] &&
					reg_wdata[`DEF_INE];
			end
			if (rx_ssel && reg_wdata[`STAT_FLAG])
				rx_tmo <= 1'b0;
			case (rx_state)
			R_IDLE: begin
				uart_rx_ready <= 1'b0;
				if (rx_en) begin
					rx_timer <= 12'h000;
					rx_state <= R_WAIT;
				end
			end
			R_WAIT: begin
				rx_timer <= rx_timer + 1'b1;
				if (ubm_rx_free) begin
					rx_idx <= 7'h00;
					rx_timer <= 12'h000;
					rx_state <= R_GET;
				end else if (rx_timer == TMO - 1'b1) begin
					rx_tmo <= 1'b1;
					rx_en <= 1'b0;
					rx_irq <= rx_ine;
					rx_state <= R_IDLE;
				end
			end
			R_GET: begin
				rx_timer <= rx_timer + 1'b1;
				uart_rx_ready <= 1'b1;
				if (rx_idx == `BUF_SIZE ||
					rx_timer == TMO - 1'b1) begin
					uart_rx_ready <= 1'b0;
					ubm_rx_done <= 1'b1;
					ubm_rx_count <= rx_idx;
					ubm_rx_nak <= 1'b0;
					ubm_rx_select <= ~ubm_rx_select;
					rx_timer <= 12'h000;
					rx_state <= R_WAIT;
					if (rx_idx != `BUF_SIZE) begin
						rx_tmo <= 1'b1;
						rx_en <= 1'b0;
						rx_irq <= rx_ine;
						rx_state <= R_IDLE;
					end
				end else if (uart_rx_valid && uart_rx_ready) begin
					rx_byte <= uart_rx_data;
					uart_rx_ready <= 1'b0;
					rx_state <= R_PUT;
				end
			end
			R_PUT: begin
				if (rx_want)
					rx_state <= R_ACK;
			end
			R_ACK: begin
				if (rx_ack) begin
					rx_idx <= rx_idx + 1'b1;
					rx_timer <= 12'h000;
					rx_state <= R_GET;
				end
			end
			default: rx_state <= R_IDLE;
			endcase
			if (rx_en && ubm_error) begin
				rx_en <= 1'b0;
				rx_irq <= rx_ine;
				uart_rx_ready <= 1'b0;
				rx_state <= R_IDLE;
			end else if (!rx_en && !rx_wsel) begin
				uart_rx_ready <= 1'b0;
				rx_state <= R_IDLE;
			end
		end
	end

	// ****************************************
	// Register read-back
	// ****************************************
	always @(posedge clk_sys) begin
		if (!resetn) begin
			reg_rdata <= `RDATA_RST;
		end else if (reg_rd) begin
			case (reg_addr)
			`TX_DEF_ADDR: reg_rdata <= def_byte(tx_en, tx_ine,
				tx_cnt_mode, ubm_tx_select, 1'b1, ubm_tx_edb);
			`TX_STAT_ADDR: reg_rdata <= {7'h00, tx_partial_packet_flag};
			`RX_DEF_ADDR: reg_rdata <= def_byte(rx_en, rx_ine,
				rx_cnt_mode, ubm_rx_select, 1'b0, ubm_rx_edb);
			`RX_STAT_ADDR: reg_rdata <= {7'h00, rx_tmo};
			default: reg_rdata <= `RDATA_RST;
			endcase
		end else begin
			reg_rdata <= `RDATA_RST;
		end
	end
endmodule // usb_uart_dma_channels
`default_nettype wire

// File: usb_uart_dma_map.vh
`ifndef USB_UART_DMA_MAP_VH
`define USB_UART_DMA_MAP_VH
// ****************************************
// Register offsets
// ****************************************
`define TX_DEF_ADDR 16'hffe0
`define TX_STAT_ADDR 16'hffe1
`define RX_DEF_ADDR 16'hffe4
`define RX_STAT_ADDR 16'hffe5
// ****************************************
// Channel definition and status fields
// ****************************************
`define DEF_EDB_HI 2
`define DEF_EDB_LO 0
`define DEF_DIR 3
`define DEF_XY 4
`define DEF_CNT 5
`define DEF_INE 6
`define DEF_EN 7
`define STAT_FLAG 0
// ****************************************
// Reset values
// ****************************************
`define EDB_RST 3'h0
`define BIT_RST 1'b0
`define RDATA_RST 8'h00
// ****************************************
// Sizes and timing
// ****************************************
`define BUF_SIZE 7'h40
`define FIFO_DEPTH 16
`define TIMEOUT_NS 10000
`define CLK_NS 5
`define TIMEOUT_CYC ((`TIMEOUT_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// File: usb_uart_dma_chk.sv
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module usb_uart_dma_chk (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Register port
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Memory, buffer manager, interrupt
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [2:0] ubm_tx_edb,
	input wire logic ubm_tx_select,
	input wire logic ubm_tx_done,
	input wire logic ubm_rx_select,
	input wire logic ubm_rx_done,
	input wire logic ubm_rx_nak,
	input wire logic [6:0] ubm_rx_count,
	input wire logic tx_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// Read data only in the cycle after a read strobe
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("Read data not idle");
	dir_bit_a: assert property (
		$past(reg_rd) && $past(reg_addr) == 16'hffe0 |-> reg_rdata[3])
		else $error("Direction bit reads 0");
	stat_hi_a: assert property (
		$past(reg_rd) && $past(reg_addr) == 16'hffe1 |-> reg_rdata[7:1] == 7'h00)
		else $error("Status upper bits set");
	// Descriptor pointer follows a write
	edb_write_a: assert property (
		reg_wr && reg_addr == 16'hffe0 |=>
		{5'h00, ubm_tx_edb} == ($past(reg_wdata) & 8'h07))
		else $error("Pointer not written");
	// Buffer select toggles with each buffer end
	tx_toggle_a: assert property (
		ubm_tx_done |-> ubm_tx_select != $past(ubm_tx_select))
		else $error("Transmit select not toggled");
	rx_toggle_a: assert property (
		ubm_rx_done |-> ubm_rx_select != $past(ubm_rx_select))
		else $error("Receive select not toggled");
	irq_pulse_a: assert property (tx_irq |=> !tx_irq)
		else $error("Interrupt longer than a cycle");
	rx_wback_a: assert property (
		ubm_rx_done |-> !ubm_rx_nak && ubm_rx_count <= 7'h40)
		else $error("Bad receive write-back");
	mem_single_a: assert property (
		mem_rd || mem_wr |=> !mem_rd && !mem_wr)
		else $error("Memory request too soon");
endmodule // usb_uart_dma_chk

bind usb_uart_dma_channels usb_uart_dma_chk chk (.clk_sys, .resetn,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mem_rd, .mem_wr,
	.ubm_tx_edb, .ubm_tx_select, .ubm_tx_done, .ubm_rx_select, .ubm_rx_done,
	.ubm_rx_nak, .ubm_rx_count, .tx_irq);
`default_nettype wire

// File: usb_uart_dma_far.sv
`default_nettype none
// ****************************************
// Memory, buffer manager and UART model
// ****************************************
module usb_uart_dma_far (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Memory
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output var logic [7:0] mem_rdata,
	output var logic mem_ack,
	// Buffer manager
	input wire logic ubm_tx_select,
	input wire logic ubm_tx_done,
	output wire logic ubm_tx_loaded,
	output wire logic [15:0] ubm_tx_base,
	output wire logic [6:0] ubm_tx_count,
	input wire logic ubm_rx_select,
	output wire logic ubm_rx_free,
	output wire logic [15:0] ubm_rx_base,
	// UART
	input wire logic [7:0] uart_tx_data,
	input wire logic uart_tx_valid,
	output wire logic uart_tx_ready,
	output wire logic [7:0] uart_rx_data,
	output wire logic uart_rx_valid,
	input wire logic uart_rx_ready,
	// Scenario control
	input wire logic tx_load,
	input wire logic [7:0] rx_limit
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ram [0:65535];
	logic [7:0] tx_seen [0:127];
	int tx_n;
	logic [1:0] left, wait_n, ph;
	logic busy, slow;
	logic [7:0] rx_n;
	// A full buffer, then a short one of two bytes
	// Loaded drops with the done pulse so a spent buffer is not reused
	assign ubm_tx_loaded = left != 2'd0 && !ubm_tx_done;
	assign ubm_tx_count = (left == 2'd1) ? 7'h02 : 7'h40;
	assign ubm_tx_base = ubm_tx_select ? 16'h1180 : 16'h1000;
	assign ubm_rx_free = resetn;
	assign ubm_rx_base = ubm_rx_select ? 16'h2080 : 16'h2000;
	assign uart_tx_ready = ph != 2'd3;
	assign uart_rx_valid = rx_n < rx_limit;
	assign uart_rx_data = uart_rx_valid ? 8'h80 + rx_n : 8'h7f - rx_n;
	// Slow and prompt acks alternate, data scrambled when idle
	always @(posedge clk_sys) begin
		ph <= ph + 2'd1;
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (!resetn) begin
			{busy, slow, left, ph, rx_n, mem_rdata} <= '0;
			tx_n <= 0;
		end else begin
			if (tx_load)
				left <= 2'd2;
			else if (ubm_tx_done && left != 2'd0)
				left <= left - 2'd1;
			if (uart_tx_valid && uart_tx_ready) begin
				tx_seen[tx_n[6:0]] <= uart_tx_data;
				tx_n <= tx_n + 1;
			end
			if (uart_rx_valid && uart_rx_ready)
				rx_n <= rx_n + 8'd1;
			if (mem_rd || mem_wr) begin
				busy <= 1'b1;
				wait_n <= slow ? 2'd2 : 2'd0;
				slow <= ~slow;
				if (mem_wr)
					ram[mem_addr] <= mem_wdata;
			end else if (busy && wait_n != 2'd0) begin
				wait_n <= wait_n - 2'd1;
			end else if (busy) begin
				mem_ack <= 1'b1;
				mem_rdata <= mem_addr[7:0] + 8'h11;
				busy <= 1'b0;
			end
		end
	end
endmodule // usb_uart_dma_far
`default_nettype wire

// File: testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic ubm_error = 1'b0;
	logic tx_load = 1'b0;
	logic [7:0] rx_limit = 8'h00;
	int num_errors = 0;
	int n_compared = 0;
	int tx_irqs = 0;
	int rx_irqs = 0;
	wire logic [15:0] mem_addr, ubm_tx_base, ubm_rx_base;
	wire logic [7:0] reg_rdata, mem_wdata, mem_rdata, uart_tx_data, uart_rx_data;
	wire logic [6:0] ubm_tx_count, ubm_rx_count;
	wire logic [2:0] ubm_tx_edb, ubm_rx_edb;
	wire logic mem_rd, mem_wr, mem_ack, ubm_tx_select, ubm_tx_loaded;
	wire logic ubm_tx_done, ubm_rx_select, ubm_rx_free, ubm_rx_done, ubm_rx_nak;
	wire logic uart_tx_valid, uart_tx_ready, uart_rx_valid, uart_rx_ready;
	wire logic tx_irq, rx_irq;
	usb_uart_dma_channels DUT (.clk_sys, .resetn, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .mem_rd, .mem_wr, .mem_addr, .mem_wdata,
		.mem_rdata, .mem_ack, .ubm_tx_edb, .ubm_tx_select, .ubm_tx_loaded,
		.ubm_tx_base, .ubm_tx_count, .ubm_tx_done, .ubm_rx_edb, .ubm_rx_select,
		.ubm_rx_free, .ubm_rx_base, .ubm_rx_done, .ubm_rx_count, .ubm_rx_nak,
		.ubm_error, .uart_tx_data, .uart_tx_valid, .uart_tx_ready, .uart_rx_data,
		.uart_rx_valid, .uart_rx_ready, .tx_irq, .rx_irq);
	usb_uart_dma_far far (.clk_sys, .resetn, .mem_rd, .mem_wr, .mem_addr,
		.mem_wdata, .mem_rdata, .mem_ack, .ubm_tx_select, .ubm_tx_done,
		.ubm_tx_loaded, .ubm_tx_base, .ubm_tx_count, .ubm_rx_select,
		.ubm_rx_free, .ubm_rx_base, .uart_tx_data, .uart_tx_valid,
		.uart_tx_ready, .uart_rx_data, .uart_rx_valid, .uart_rx_ready,
		.tx_load, .rx_limit);
	// Clock and interrupt pulse counters
	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		tx_irqs <= tx_irqs + (tx_irq === 1'b1);
		rx_irqs <= rx_irqs + (rx_irq === 1'b1);
	end
	// ****************************************
	// Bus and comparison tasks
	// ****************************************
	task check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		v = reg_rdata;
	endtask
	task wait_off(input logic [15:0] a, output logic [7:0] v);
		for (int i = 0; i < 3000; i++) begin
			rd(a, v);
			if (v[7] === 1'b0)
				break;
		end
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task s_reset;
		logic [7:0] v;
		rd(16'hffe0, v);
		check(v, 8'h08);
		rd(16'hffe1, v);
		check(v, 8'h00);
		rd(16'hffe2, v);
		check(v, 8'h00);
		rd(16'hffe4, v);
		check(v, 8'h00);
		check(ubm_rx_edb, 3'h0);
		check(ubm_rx_nak, 1'b1);
	endtask
	task s_fields;
		logic [7:0] v;
		for (int e = 1; e < 4; e++) begin
			wr(16'hffe0, 8'h20 | e[7:0]);
			rd(16'hffe0, v);
			check(v, 8'h28 | e[7:0]);
			check(ubm_tx_edb, e[2:0]);
		end
	endtask
	task s_tx;
		logic [7:0] v;
		@(posedge clk_sys) tx_load <= 1'b1;
		@(posedge clk_sys) tx_load <= 1'b0;
		wr(16'hffe0, 8'he1);
		wait_off(16'hffe0, v);
		check(v, 8'h69);
		repeat (60) @(posedge clk_sys);
		check(far.tx_n, 66);
		for (int i = 0; i < 66; i++)
			check(far.tx_seen[i], i < 64 ? i + 8'h11 : i + 8'h51);
		check(tx_irqs, 1);
		rd(16'hffe1, v);
		check(v, 8'h01);
		wr(16'hffe1, 8'h00);
		rd(16'hffe1, v);
		check(v, 8'h01);
		wr(16'hffe1, 8'h01);
		rd(16'hffe1, v);
		check(v, 8'h00);
	endtask
	// Short packet with interrupts off keeps the channel running
	task s_err;
		logic [7:0] v;
		@(posedge clk_sys) tx_load <= 1'b1;
		@(posedge clk_sys) tx_load <= 1'b0;
		wr(16'hffe0, 8'ha1);
		repeat (500) @(posedge clk_sys);
		check(far.tx_n, 132);
		rd(16'hffe0, v);
		check(v, 8'ha9);
		rd(16'hffe1, v);
		check(v, 8'h01);
		@(posedge clk_sys) ubm_error <= 1'b1;
		repeat (4) @(posedge clk_sys);
		ubm_error <= 1'b0;
		rd(16'hffe0, v);
		check(v, 8'h29);
		check(tx_irqs, 1);
	endtask
	task s_rx;
		logic [7:0] v;
		wr(16'hffe4, 8'he1);
		@(posedge clk_sys) rx_limit <= 8'd64;
		for (int i = 0; i < 2000 && ubm_rx_done !== 1'b1; i++)
			@(negedge clk_sys);
		check(ubm_rx_count, 7'h40);
		check(ubm_rx_nak, 1'b0);
		check(ubm_rx_edb, 3'h1);
		for (int i = 0; i < 64; i++)
			check(far.ram[16'h2000 + i], 8'h80 + i);
		wait_off(16'hffe4, v);
		check(v & 8'h88, 8'h00);
		rd(16'hffe5, v);
		check(v, 8'h01);
		check(rx_irqs, 1);
	endtask
	task close_out;
		$display("Compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Main sequence after five cycles of reset
	initial begin
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		s_reset;
		s_fields;
		s_tx;
		s_err;
		s_rx;
		// Reset in mid-run must restore both definition bytes, transmit status and receive outputs
		@(posedge clk_sys) resetn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		s_reset;
		close_out;
	end
	// Watchdog well beyond the expected run
	initial begin
		#100us;
		num_errors++;
		close_out;
	end
endmodule // testbench
`default_nettype wire
